//--- core/machine_check.sv
// Purpose: malfunction register, power-fail sequence, start watchdog
// Assumes: system initialize drives resetn; inputs are async where noted
// Notes: relay delay lives outside; power_down_n feeds the relay driver
//
// Functional notes
// - Any of register bits 11..15 set raises malfunction_irq.
// - Clear function clears bits 11..15 where bus bits 27..31 are one.
// - System initialize clears bits 10..15; straps keep strapped values.
// - Sense gates bits 15..4 onto source bus 31..20, plus LGVC codes.
// - Power-fail detect starts a one millisecond early timer.
// - Start of early interval sets bit 15, raising malfunction irq.
// - End of early interval sets primary flip-flop and fail line.
// - Primary flip-flop set starts one millisecond extended timer.
// - Stop set by extended timer end or power-off, whichever first.
// - Stop set holds power_down_n low.
// - Initialize asserted while relay de-energized, released after.
// - Clear requests clear stop unless power_off_fn is high in the same cycle, releasing power-down.
// - Every module start request without a module finish in the same cycle starts a 30 microsecond timer.
// - Any module finish, whatever module_select, clears the timer and timeout flip-flop.
// - Timer runs only while timer_kill is low.
// - Non-mux timeout sets bit 11, pseudo finish, malfunction irq.
// - Mux timeout leaves register, drives false sync 0010 (LGVC) on cc_out, finish.
// - Mux sense timeout also gates 0x004 onto source bits 16..31.
`timescale 1ns/1ns
`include "mc_cfg.svh"
module machine_check
  import mc_pkg::*;
#(
  parameter int unsigned EPF_CYCLES = `EPF_CYCLES,
  parameter int unsigned XPF_CYCLES = `XPF_CYCLES,
  parameter int unsigned STM_CYCLES = `STM_CYCLES,
  parameter logic [15:0] STRAP_VALUE = `STRAP_RESET
) (
  // Clock and system initialize
  input wire logic sys_clk,
  input wire logic resetn,
  // Relay sense and initialize output
  input wire logic relay_energized,
  output logic system_init_n,
  // Error sources
  input wire err_in_t err_in,
  input wire logic display_single_step_ff,
  // Register functions
  input wire logic sense_malfunction_fn,
  input wire logic clear_malfunction_fn,
  input wire logic [31:0] bus_in,
  output logic [31:0] source_bus,
  output cc_t cc_out,
  output cc_t cc_out_b,
  output logic malfunction_irq,
  // Power-fail sequence
  input wire logic power_fail_detect,
  input wire logic power_off_fn,
  input wire logic power_off_req,
  input wire logic lock_switch_req,
  input wire logic init_req_n,
  input wire logic external_a_req_n,
  input wire logic external_b_req_n,
  output logic primary_power_fail_ff,
  output logic power_fail_line_n,
  output logic stop_ff_q,
  output logic power_down_n,
  // Start watchdog
  input wire logic module_start_req,
  input wire logic module_finish,
  input wire logic [2:0] module_select,
  input wire logic mux_bus_op,
  input wire logic mux_sense_op,
  input wire logic timer_kill,
  output logic pseudo_finish,
  output logic start_timeout_ff
);
  initial begin
    if (EPF_CYCLES < 1 || XPF_CYCLES < 1 || STM_CYCLES < 1)
      $error("machine_check: interval counts must be at least 1");
  end
  // ----------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------
  // two-flop synchronisers
  logic [1:0] pfd_sync_reg, kill_sync_reg;
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      pfd_sync_reg <= 2'b00;
      kill_sync_reg <= 2'b00;
    end else begin
      pfd_sync_reg <= {pfd_sync_reg[0], power_fail_detect};
      kill_sync_reg <= {kill_sync_reg[0], timer_kill};
    end
  end
  wire pfd_s = pfd_sync_reg[1];
  wire kill_s = kill_sync_reg[1];
  // ----------------------------------------------------------
  // Power-fail sequence
  // ----------------------------------------------------------
  pf_state_t pf_reg, pf_next;
  logic pfd_d_reg, pfd_d_next;
  logic ppf_reg, ppf_next, stop_reg, stop_next;
  logic epf_done, xpf_done, epf_run, xpf_run;
  logic epf_start, xpf_start, stop_clear;
  // Leading edge only, so a held detect does not retrigger
  assign epf_start = pfd_s && !pfd_d_reg && pf_reg == PF_IDLE;
  assign stop_clear = power_off_req || lock_switch_req || !init_req_n ||
                      !external_a_req_n || !external_b_req_n;
  always_comb begin
    pf_next = pf_reg;
    ppf_next = ppf_reg;
    stop_next = stop_reg;
    pfd_d_next = pfd_s;
    xpf_start = 1'b0;
    case (pf_reg)
      PF_IDLE: begin
        if (epf_start) pf_next = PF_EARLY;
      end
      PF_EARLY: begin
        if (epf_done) begin
          ppf_next = 1'b1;
          xpf_start = 1'b1;
          pf_next = PF_EXT;
        end
      end
      PF_EXT: begin
        if (xpf_done) begin
          stop_next = 1'b1;
          pf_next = PF_STOP;
        end
      end
      PF_STOP: pf_next = PF_STOP;
      default: pf_next = PF_IDLE;
    endcase
    if (power_off_fn && ppf_reg) begin
      stop_next = 1'b1;
      pf_next = PF_STOP;
    end
    if (stop_clear && !power_off_fn) begin
      stop_next = 1'b0;
      ppf_next = 1'b0;
      pf_next = PF_IDLE;
    end
  end
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      pf_reg <= PF_IDLE;
      ppf_reg <= 1'b0;
      stop_reg <= 1'b0;
      pfd_d_reg <= 1'b0;
    end else begin
      pf_reg <= pf_next;
      ppf_reg <= ppf_next;
      stop_reg <= stop_next;
      pfd_d_reg <= pfd_d_next;
    end
  end
  interval_timer #(.CYCLES(EPF_CYCLES)) u_epf (
    .sys_clk(sys_clk), .resetn(resetn), .start(epf_start),
    .clear(stop_clear), .run_en(1'b1),
    .running(epf_run), .done(epf_done)
  );
  interval_timer #(.CYCLES(XPF_CYCLES)) u_xpf (
    .sys_clk(sys_clk), .resetn(resetn), .start(xpf_start),
    .clear(stop_clear), .run_en(1'b1),
    .running(xpf_run), .done(xpf_done)
  );
  assign primary_power_fail_ff = ppf_reg;
  assign power_fail_line_n = !ppf_reg;
  assign stop_ff_q = stop_reg;
  assign power_down_n = !stop_reg;
  assign system_init_n = relay_energized;
  // ----------------------------------------------------------
  // Start watchdog
  // ----------------------------------------------------------
  localparam logic [3:0] FS_CVGL = `FALSE_SYNC_CC; // C V G L order
  logic stm_done, stm_run;
  logic tmo_reg, tmo_next, pfin_reg, pfin_next;
  logic [3:0] fsync_reg, fsync_next;
  logic msense_reg, msense_next, stf_set;
  interval_timer #(.CYCLES(STM_CYCLES)) u_stm (
    .sys_clk(sys_clk), .resetn(resetn), .start(module_start_req),
    .clear(module_finish), .run_en(!kill_s),
    .running(stm_run), .done(stm_done)
  );
  always_comb begin
    tmo_next = tmo_reg;
    pfin_next = 1'b0;
    fsync_next = 4'h0;
    msense_next = 1'b0;
    stf_set = 1'b0;
    if (module_finish || module_start_req) begin
      tmo_next = 1'b0;
    end else if (stm_done) begin
      tmo_next = 1'b1;
      pfin_next = 1'b1;
      if (mux_bus_op) begin
        // false sync, reordered to L G V C: overflow only
        fsync_next = {FS_CVGL[0], FS_CVGL[1], FS_CVGL[2], FS_CVGL[3]};
        msense_next = mux_sense_op;
      end else begin
        stf_set = 1'b1;
      end
    end
  end
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      tmo_reg <= 1'b0;
      pfin_reg <= 1'b0;
      fsync_reg <= 4'h0;
      msense_reg <= 1'b0;
    end else begin
      tmo_reg <= tmo_next;
      pfin_reg <= pfin_next;
      fsync_reg <= fsync_next;
      msense_reg <= msense_next;
    end
  end
  assign pseudo_finish = pfin_reg;
  assign start_timeout_ff = tmo_reg;
  // ----------------------------------------------------------
  // Malfunction register
  // ----------------------------------------------------------
  logic [15:0] mmr_reg, mmr_next;
  logic [31:0] src_reg, src_next;
  cc_t cc_reg, cc_next;
  // Straps come from the parameter, so initialize never loses them
  always_comb begin
    mmr_next = STRAP_VALUE;
    mmr_next[15:10] = mmr_reg[15:10];
    mmr_next[7] = display_single_step_ff;
    if (clear_malfunction_fn)
      mmr_next[15:11] = mmr_reg[15:11] & ~bus_in[31:27];
    // early interval sets bit 15; sets beat clears
    mmr_next[15:11] = mmr_next[15:11] | {epf_start, err_in[3:1], stf_set};
    mmr_next[`MMR_BIT_CONSOLE_ATTENTION] = mmr_reg[`MMR_BIT_CONSOLE_ATTENTION] | err_in.console_attn;
  end
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) mmr_reg <= {6'h00, STRAP_VALUE[9:0]};
    else mmr_reg <= mmr_next;
  end
  assign malfunction_irq = |mmr_reg[15:11];
  always_comb begin
    src_next = 32'h0000_0000;
    cc_next = '0;
    if (sense_malfunction_fn) begin
      src_next[31:20] = mmr_reg[15:4];
      cc_next = mmr_reg[15:12];
    end
    if (fsync_next != 4'h0) cc_next = fsync_next;
    if (msense_next) src_next[31:16] = `MUX_SENSE_VAL;
  end
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      src_reg <= 32'h0000_0000;
      cc_reg <= '0;
    end else begin
      src_reg <= src_next;
      cc_reg <= cc_next;
    end
  end
  assign source_bus = src_reg;
  assign cc_out = cc_reg;
  assign cc_out_b = cc_reg;
  // ----------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------
  default clocking dc @(posedge sys_clk);
  endclocking
  default disable iff (!resetn);
  sequence s_ppf_rise;
    !ppf_reg ##1 ppf_reg;
  endsequence
  a_irq_from_bits: assert property (
    (|err_in[3:1]) |=> malfunction_irq)
    else $error("irq mismatch");
  a_clear_selective: assert property (
    clear_malfunction_fn && bus_in[31] && !epf_start |=> !mmr_reg[15])
    else $error("clear failed");
  a_epf_sets_15: assert property (
    epf_start |=> mmr_reg[15] && malfunction_irq)
    else $error("bit 15 not set");
  a_ppf_starts_xpf: assert property (
    s_ppf_rise |-> xpf_run && !power_fail_line_n)
    else $error("extended timer idle");
  a_stop_power_dn: assert property (
    xpf_done && pf_reg == PF_EXT && !stop_clear |=> !power_down_n)
    else $error("power down not held");
  a_poweroff_stop: assert property (
    power_off_fn && ppf_reg |=> stop_reg)
    else $error("stop not set");
  a_stf_nonmux: assert property (
    stf_set |=> mmr_reg[11] && pseudo_finish)
    else $error("timeout flag missing");
  a_mux_sync: assert property (
    stm_done && mux_bus_op && !module_finish && !module_start_req
    |=> cc_out == 4'h2 && pseudo_finish && $stable(mmr_reg[11]))
    else $error("false sync missing");
  a_mux_sense: assert property (
    msense_reg |-> source_bus[31:16] == 16'h0004)
    else $error("sense value wrong");
  a_finish_clears: assert property (
    module_finish |=> !tmo_reg && !stm_run)
    else $error("finish ignored");
endmodule : machine_check

//--- include/mc_cfg.svh
// Purpose: constants for the machine-check and power-fail logic
// Assumes: 250 MHz system clock
// Notes: MMR_ bit positions refer to the 16-bit malfunction register; SRC_MMR_LSB and CMB_LSB are positions on the 32-bit buses
`ifndef MC_CFG_SVH
`define MC_CFG_SVH
`define CLK_MHZ 250
`define EPF_TIME_US 1000
`define XPF_TIME_US 1000
`define STM_TIME_US 30
`define EPF_CYCLES (`EPF_TIME_US * `CLK_MHZ)
`define XPF_CYCLES (`XPF_TIME_US * `CLK_MHZ)
`define STM_CYCLES (`STM_TIME_US * `CLK_MHZ)
`define MMR_BIT_EPF 15
`define MMR_BIT_STF 11
`define MMR_BIT_CONSOLE_ATTENTION 10
`define MMR_IRQ_LO 11
`define MMR_IRQ_HI 15
`define MMR_CLR_LO 10
`define MMR_SRC_LSB 4
`define SRC_MMR_LSB 20
`define CMB_LSB 27
`define FALSE_SYNC_CC 4'h4
`define MUX_SENSE_VAL 16'h0004
`define STRAP_RESET 16'h0000
`endif

//--- include/mc_pkg.sv
// Purpose: types for the machine-check and power-fail logic
// Assumes: nothing beyond the config header
// Notes: holds types only
package mc_pkg;
  typedef enum logic [1:0] {
    PF_IDLE = 2'b00,
    PF_EARLY = 2'b01,
    PF_EXT = 2'b10,
    PF_STOP = 2'b11
  } pf_state_t;
  typedef struct packed {
    logic less;
    logic greater;
    logic overflow;
    logic carry;
  } cc_t;
  typedef struct packed {
    logic parity_instr;
    logic parity_data;
    logic parity_auto;
    logic console_attn;
  } err_in_t;
endpackage : mc_pkg

//--- core/interval_timer.sv
// Purpose: restartable one-shot cycle counter
// Assumes: start and clear are single-clock requests
// Notes: done pulses for one cycle when the count expires
`timescale 1ns/1ns
module interval_timer #(
  parameter int unsigned CYCLES = 250
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // Control
  input wire logic start,
  input wire logic clear,
  input wire logic run_en,
  // Status
  output logic running,
  output logic done
);
  localparam int W = $clog2(CYCLES + 1);
  initial begin
    if (CYCLES < 1) $error("interval_timer: CYCLES must be at least 1");
  end
  logic [W-1:0] cnt_reg, cnt_next;
  logic run_reg, run_next, done_reg, done_next;

  always_comb begin
    cnt_next = cnt_reg;
    run_next = run_reg;
    done_next = 1'b0;
    if (clear) begin
      run_next = 1'b0;
      cnt_next = '0;
    end else if (start) begin
      run_next = 1'b1;
      cnt_next = '0;
    end else if (run_reg && run_en) begin
      if (cnt_reg == W'(CYCLES - 1)) begin
        run_next = 1'b0;
        done_next = 1'b1;
      end else begin
        cnt_next = cnt_reg + 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      cnt_reg <= '0;
      run_reg <= 1'b0;
      done_reg <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      run_reg <= run_next;
      done_reg <= done_next;
    end
  end

  assign running = run_reg;
  assign done = done_reg;
endmodule : interval_timer

//--- sim/cpu_side_model.sv
// Purpose: CPU microsequencer and addressed module, plus initialize relay
// Assumes: outputs change only just after the rising edge
// Notes: fin_dly of zero leaves a start unanswered, as a dead module would
`timescale 1ns/1ns
module cpu_side_model (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // Bench controls
  input wire logic [7:0] fin_dly,
  input wire logic save_en,
  // Device side
  input wire logic module_start_req,
  input wire logic primary_power_fail_ff,
  input wire logic power_down_n,
  output logic module_finish,
  output logic power_off_fn,
  output logic relay_energized
);
  logic [7:0] fin_cnt;
  logic [3:0] save_cnt;
  logic [3:0] relay_sr;
  logic ppf_d;
  // Relay charges slowly, so it lags power_down_n by a few cycles
  assign relay_energized = relay_sr[3];
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      fin_cnt <= 8'h00;
      save_cnt <= 4'h0;
      relay_sr <= 4'hf;
      ppf_d <= 1'b0;
      module_finish <= 1'b0;
      power_off_fn <= 1'b0;
    end else begin
      relay_sr <= {relay_sr[2:0], power_down_n};
      ppf_d <= primary_power_fail_ff;
      module_finish <= 1'b0;
      power_off_fn <= 1'b0;
      if (module_start_req) begin
        fin_cnt <= fin_dly;
      end else if (fin_cnt != 8'h00) begin
        fin_cnt <= fin_cnt - 8'h01;
        module_finish <= (fin_cnt == 8'h01);
      end
      if (primary_power_fail_ff && !ppf_d && save_en) begin
        save_cnt <= 4'h3;
      end else if (save_cnt != 4'h0) begin
        save_cnt <= save_cnt - 4'h1;
        power_off_fn <= (save_cnt == 4'h1);
      end
    end
  end
endmodule : cpu_side_model

//--- sim/testbench.sv
// Purpose: self-checking bench for the machine-check block
// Assumes: shortened interval counts of 20, 20 and 10 cycles
// Notes: outputs are sampled at the falling edge to stay clear of races
`timescale 1ns/1ns
module testbench
  import mc_pkg::*;
;
  localparam int EPF_C = 20;
  localparam int XPF_C = 20;
  localparam int STM_C = 10;
  logic sys_clk, resetn, relay_energized, system_init_n;
  err_in_t err_in;
  logic display_single_step_ff, sense_malfunction_fn, clear_malfunction_fn;
  logic [31:0] bus_in, source_bus;
  cc_t cc_out, cc_out_b;
  logic malfunction_irq, power_fail_detect, power_off_fn, power_off_req;
  logic lock_switch_req, init_req_n, external_a_req_n, external_b_req_n;
  logic primary_power_fail_ff, power_fail_line_n, stop_ff_q, power_down_n;
  logic module_start_req, module_finish, mux_bus_op, mux_sense_op;
  logic timer_kill, pseudo_finish, start_timeout_ff, save_en;
  logic [2:0] module_select;
  logic [7:0] fin_dly;
  int err_total, compares, cyc, n;

  machine_check #(.EPF_CYCLES(EPF_C), .XPF_CYCLES(XPF_C),
    .STM_CYCLES(STM_C)) i_dut (.sys_clk, .resetn, .relay_energized,
    .system_init_n, .err_in, .display_single_step_ff,
    .sense_malfunction_fn, .clear_malfunction_fn, .bus_in, .source_bus,
    .cc_out, .cc_out_b, .malfunction_irq, .power_fail_detect,
    .power_off_fn, .power_off_req, .lock_switch_req, .init_req_n,
    .external_a_req_n, .external_b_req_n, .primary_power_fail_ff,
    .power_fail_line_n, .stop_ff_q, .power_down_n, .module_start_req,
    .module_finish, .module_select, .mux_bus_op, .mux_sense_op,
    .timer_kill, .pseudo_finish, .start_timeout_ff);
  cpu_side_model i_cpu (.sys_clk, .resetn, .fin_dly, .save_en,
    .module_start_req, .primary_power_fail_ff, .power_down_n,
    .module_finish, .power_off_fn, .relay_energized);

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic close_out;
    $display("compares=%0d mismatches=%0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : close_out
  task automatic chk_bus(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_bus
  task automatic chk_bit(input logic got, input logic exp);
    chk_bus({31'h0, got}, {31'h0, exp});
  endtask : chk_bit
  task automatic sense(input logic [31:0] eb);
    @(posedge sys_clk);
    sense_malfunction_fn <= 1'b1;
    @(posedge sys_clk);
    sense_malfunction_fn <= 1'b0;
    @(negedge sys_clk);
    chk_bus(source_bus, eb);
  endtask : sense
  task automatic clear(input logic [31:0] mask);
    @(posedge sys_clk);
    clear_malfunction_fn <= 1'b1;
    bus_in <= mask;
    @(posedge sys_clk);
    clear_malfunction_fn <= 1'b0;
    @(negedge sys_clk);
  endtask : clear
  task automatic start;
    @(posedge sys_clk);
    module_start_req <= 1'b1;
    @(posedge sys_clk);
    module_start_req <= 1'b0;
    @(negedge sys_clk);
  endtask : start
  task automatic set_clr(input int k);
    power_off_req <= (k == 0);
    lock_switch_req <= (k == 1);
    init_req_n <= (k != 2);
    external_a_req_n <= (k != 3);
    external_b_req_n <= (k != 4);
  endtask : set_clr
  function automatic logic probe(input int sel);
    case (sel)
      0: return pseudo_finish;
      1: return primary_power_fail_ff;
      default: return stop_ff_q;
    endcase
  endfunction : probe
  // Counts falling edges until the chosen flag is seen, bounded
  task automatic wait_for(input int sel, input int lim);
    n = 0;
    while (probe(sel) !== 1'b1 && n < lim) begin
      @(negedge sys_clk);
      n++;
    end
  endtask : wait_for

  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 4000) begin
      err_total++;
      close_out;
    end
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    resetn = 1'b0;
    err_in = 4'h0;
    display_single_step_ff = 1'b1;
    sense_malfunction_fn = 1'b0;
    clear_malfunction_fn = 1'b0;
    bus_in = 32'h0000_0000;
    power_fail_detect = 1'b0;
    set_clr(9);
    module_start_req = 1'b0;
    module_select = 3'h2;
    mux_bus_op = 1'b0;
    mux_sense_op = 1'b0;
    timer_kill = 1'b0;
    fin_dly = 8'h03;
    save_en = 1'b0;
    repeat (12) @(posedge sys_clk);
    resetn <= 1'b1;
    @(negedge sys_clk);
    chk_bit(power_down_n, 1'b1);
    chk_bit(power_fail_line_n, 1'b1);
    chk_bit(malfunction_irq, 1'b0);
    $display("test reset done");
    @(posedge sys_clk);
    err_in <= 4'hf;
    @(posedge sys_clk);
    err_in <= 4'h0;
    sense(32'h7480_0000);
    chk_bus({28'h0, cc_out}, 32'h7);
    chk_bit(malfunction_irq, 1'b1);
    clear(32'h4000_0000);
    sense(32'h3480_0000);
    clear(32'hf800_0000);
    sense(32'h0480_0000);
    chk_bit(malfunction_irq, 1'b0);
    $display("test register done");
    start;
    wait_for(0, STM_C + 8);
    chk_bit(n == STM_C + 8, 1'b1);
    chk_bit(start_timeout_ff, 1'b0);
    fin_dly <= 8'h00;
    start;
    wait_for(0, STM_C + 6);
    chk_bit(n inside {[STM_C:STM_C + 3]}, 1'b1);
    chk_bit(start_timeout_ff, 1'b1);
    chk_bit(malfunction_irq, 1'b1);
    sense(32'h0c80_0000);
    clear(32'h0800_0000);
    chk_bit(malfunction_irq, 1'b0);
    @(posedge sys_clk);
    timer_kill <= 1'b1;
    repeat (4) @(negedge sys_clk);
    start;
    wait_for(0, STM_C + 8);
    chk_bit(n == STM_C + 8, 1'b1);
    @(posedge sys_clk);
    timer_kill <= 1'b0;
    wait_for(0, STM_C + 6);
    chk_bit(pseudo_finish, 1'b1);
    clear(32'h0800_0000);
    $display("test watchdog done");
    @(posedge sys_clk);
    mux_bus_op <= 1'b1;
    mux_sense_op <= 1'b1;
    start;
    wait_for(0, STM_C + 6);
    chk_bus({28'h0, cc_out}, 32'h2);
    chk_bus({28'h0, cc_out_b}, 32'h2);
    chk_bus({16'h0, source_bus[31:16]}, 32'h0004);
    @(posedge sys_clk);
    mux_bus_op <= 1'b0;
    mux_sense_op <= 1'b0;
    sense(32'h0480_0000);
    chk_bit(malfunction_irq, 1'b0);
    $display("test mux timeout done");
    for (int k = 0; k < 5; k++) begin
      save_en <= (k % 2 == 0);
      clear(32'h8000_0000);
      chk_bit(malfunction_irq, 1'b0);
      @(posedge sys_clk);
      power_fail_detect <= 1'b1;
      repeat (5) @(negedge sys_clk);
      chk_bit(malfunction_irq, 1'b1);
      sense(32'h8480_0000);
      chk_bus({28'h0, cc_out}, 32'h8);
      wait_for(1, EPF_C + 6);
      chk_bit(n inside {[EPF_C - 5:EPF_C + 1]}, 1'b1);
      chk_bit(power_fail_line_n, 1'b0);
      wait_for(2, XPF_C + 6);
      if (k % 2 == 0) begin
        chk_bit(n <= 6, 1'b1);
      end else begin
        chk_bit(n inside {[XPF_C - 1:XPF_C + 3]}, 1'b1);
      end
      chk_bit(power_down_n, 1'b0);
      repeat (5) @(negedge sys_clk);
      chk_bit(system_init_n, 1'b0);
      @(posedge sys_clk);
      power_fail_detect <= 1'b0;
      set_clr(k);
      @(posedge sys_clk);
      set_clr(9);
      @(negedge sys_clk);
      chk_bit(power_down_n, 1'b1);
      chk_bit(primary_power_fail_ff, 1'b0);
      repeat (6) @(negedge sys_clk);
      chk_bit(system_init_n, 1'b1);
      $display("test power sequence %0d done", k);
    end
    @(posedge sys_clk);
    err_in <= 4'hf;
    display_single_step_ff <= 1'b0;
    @(posedge sys_clk);
    err_in <= 4'h0;
    resetn <= 1'b0;
    repeat (2) @(posedge sys_clk);
    resetn <= 1'b1;
    sense(32'h0000_0000);
    chk_bit(malfunction_irq, 1'b0);
    $display("test second reset done");
    close_out;
  end
endmodule : testbench
